/* hdl/hv_sync_defs.svh */
// Purpose: Named offsets, field positions, reset values and timing counts of the sync processor
// Assumes: 200 MHz core clock
// Notes:   Definitions only
`ifndef HV_SYNC_DEFS_SVH
`define HV_SYNC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ADDR_SYNC_CTRL          8'h06
`define ADDR_SYNC_POL_CTRL      8'h07
`define ADDR_HCOUNT_LO          8'h08
`define ADDR_HCOUNT_HI          8'h09
`define ADDR_VCOUNT_LO          8'h0a
`define ADDR_VCOUNT_HI          8'h0b
`define ADDR_FREE_RUN_CTRL      8'h0c
`define ADDR_HALF_FREQ_CTRL     8'h0d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_SEP_COMP            0
`define BIT_HSEL                1
`define BIT_FIXED_WIN_EN_N      2
`define BIT_INSERT_EN_N         3
`define BIT_VPOL_OUT            0
`define BIT_HPOL_OUT            1
`define BIT_VPOL_IN             2
`define BIT_HPOL_IN             3
`define BIT_VLEVEL              4
`define BIT_HLEVEL              5
`define BIT_VOUT_EN_N           6
`define BIT_HOUT_EN_N           7
`define BIT_OVF                 7
`define BIT_HALF_POL            5
`define BIT_BYPASS_N            6
`define BIT_HALF_EN_N           7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_FREE_RUN_SEL        3'h7
`define RST_POLARITY            1'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ                 200
`define SYS_MHZ                 8
`define GLITCH_NS               125
`define JITTER_NS               125
`define TICK_NS                 8000
`define INSERT_NS               2000
`define WIDEN_NS                9000
`define VSEP_NS                 5000
`define GLITCH_CYC              ((`GLITCH_NS * `CLK_MHZ + 999) / 1000)
`define JITTER_CYC              ((`JITTER_NS * `CLK_MHZ + 999) / 1000)
`define TICK_CYC                ((`TICK_NS * `CLK_MHZ) / 1000)
`define INSERT_CYC              ((`INSERT_NS * `CLK_MHZ) / 1000)
`define WIDEN_CYC               ((`WIDEN_NS * `CLK_MHZ) / 1000)
`define VSEP_CYC                ((`VSEP_NS * `CLK_MHZ + 999) / 1000)
`define SYS_DIV                 (`CLK_MHZ / `SYS_MHZ)
`define WIN_SHORT_TICKS         2048
`define WIN_LONG_TICKS          4096
`define FR_HPULSE_TICKS         8
`define FR_VPULSE_TICKS         512
`define POL_HALF                128

`endif

/* hdl/hv_sync_pkg.sv */
// Purpose: Types shared by the sync processor
// Assumes: Nothing
// Notes:   Constants live in hv_sync_defs.svh
package hv_sync_pkg;

	typedef struct packed {
		logic       sep_comp;
		logic       pulse_insert_enable_n;
		logic       fixed_window_enable_n;
		logic       hsel;
		logic       horiz_out_enable_n;
		logic       vert_out_enable_n;
		logic       horiz_output_polarity;
		logic       vert_output_polarity;
		logic [2:0] free_run_select;
		logic       half_freq_enable_n;
		logic       divide_bypass_n;
		logic       bypass_polarity;
	} ctrl_t;

	typedef struct packed {
		logic [13:0] vert_period_count;
		logic        vert_count_overflow;
		logic [11:0] horiz_pulse_count;
		logic        horiz_count_overflow;
	} counts_t;

endpackage : hv_sync_pkg

/* hdl/hv_sync_processor.sv */
// Purpose: Horizontal/vertical sync processor with measurement, separation and output control
// Assumes: Register port strobes one cycle long; sync pins synchronous to clock_in
// Notes:   Behaviour
`timescale 1ns/1ps
`include "hv_sync_defs.svh"
`default_nettype none

module hv_sync_processor #(
	parameter int POL_WIN = 256
) (
	input  wire logic       clock_in,
	input  wire logic       resetn_in,
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       write_in,
	input  wire logic       read_in,
	output logic      [7:0] rdata_out,
	input  wire logic       hsync_in,
	input  wire logic       vsync_in,
	input  wire logic       half_freq_input_in,
	output logic            horiz_sync_out,
	output logic            vert_sync_out,
	output logic            horiz_pin_sel_out,
	output logic            vert_pin_sel_out,
	output logic            half_freq_output_out,
	output logic            half_pin_sel_out
);

	// ----------------------------------------------------------------
	// Free-running timing table
	// ----------------------------------------------------------------
	function automatic logic [8:0] fr_hper(input logic [2:0] sel);
		case (sel)
			3'h0:    fr_hper = 9'h100;
			3'h1:    fr_hper = 9'h0b4;
			3'h2:    fr_hper = 9'h080;
			3'h3:    fr_hper = 9'h064;
			default: fr_hper = 9'h058;
		endcase
	endfunction : fr_hper

	function automatic logic [10:0] fr_lines(input logic [2:0] sel);
		case (sel)
			3'h0, 3'h1: fr_lines = 11'h200;
			3'h2:       fr_lines = 11'h348;
			default:    fr_lines = 11'h400;
		endcase
	endfunction : fr_lines

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	hv_sync_pkg::ctrl_t   ctrl;
	hv_sync_pkg::counts_t cnt;
	logic                 wr_sync;
	logic                 wr_pol;
	logic                 wr_free;
	logic                 wr_half;
	logic                 hov_clr;
	logic                 vov_clr;

	assign wr_sync = write_in && addr_in == `ADDR_SYNC_CTRL;
	assign wr_pol  = write_in && addr_in == `ADDR_SYNC_POL_CTRL;
	assign wr_free = write_in && addr_in == `ADDR_FREE_RUN_CTRL;
	assign wr_half = write_in && addr_in == `ADDR_HALF_FREQ_CTRL;
	assign hov_clr = write_in && addr_in == `ADDR_HCOUNT_HI && wdata_in[`BIT_OVF];
	assign vov_clr = write_in && addr_in == `ADDR_VCOUNT_HI && wdata_in[`BIT_OVF];

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			ctrl                 <= '1;
			ctrl.free_run_select <= `RST_FREE_RUN_SEL;
		end
		else
		begin
			if (wr_sync)
			begin
				ctrl.sep_comp              <= wdata_in[`BIT_SEP_COMP];
				ctrl.hsel                  <= wdata_in[`BIT_HSEL];
				ctrl.fixed_window_enable_n <= wdata_in[`BIT_FIXED_WIN_EN_N];
				ctrl.pulse_insert_enable_n <= wdata_in[`BIT_INSERT_EN_N];
			end
			if (wr_pol)
			begin
				ctrl.horiz_out_enable_n    <= wdata_in[`BIT_HOUT_EN_N];
				ctrl.vert_out_enable_n     <= wdata_in[`BIT_VOUT_EN_N];
				ctrl.horiz_output_polarity <= wdata_in[`BIT_HPOL_OUT];
				ctrl.vert_output_polarity  <= wdata_in[`BIT_VPOL_OUT];
			end
			if (wr_free)
				ctrl.free_run_select <= wdata_in[2:0];
			if (wr_half)
			begin
				ctrl.half_freq_enable_n <= wdata_in[`BIT_HALF_EN_N];
				ctrl.divide_bypass_n    <= wdata_in[`BIT_BYPASS_N];
				ctrl.bypass_polarity    <= wdata_in[`BIT_HALF_POL];
			end
		end
	end

	// ----------------------------------------------------------------
	// Clock dividers
	// ----------------------------------------------------------------
	logic [4:0]  sys_div;
	logic [10:0] tick_div;
	logic        sys_en;
	logic        tick8;

	assign sys_en = sys_div == 5'(`SYS_DIV - 1);
	assign tick8  = tick_div == 11'(`TICK_CYC - 1);

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			sys_div  <= 5'h00;
			tick_div <= 11'h000;
		end
		else
		begin
			sys_div  <= sys_en ? 5'h00 : sys_div + 5'h01;
			tick_div <= tick8 ? 11'h000 : tick_div + 11'h001;
		end
	end

	// ----------------------------------------------------------------
	// Input synchronisers, glitch filters, polarity detection
	// ----------------------------------------------------------------
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic [1:0] filt;
	logic [1:0] pol_in;

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
		end
		else
		begin
			sync_a <= {vsync_in, hsync_in};
			sync_b <= sync_a;
		end
	end

	// Channel 0 is horizontal, channel 1 vertical
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		localparam logic [7:0] LIM = 8'((ch == 0) ? `GLITCH_CYC + `JITTER_CYC : `GLITCH_CYC);
		logic [7:0] stab;
		logic [8:0] samples;
		logic [8:0] highs;

		always_ff @(posedge clock_in)
		begin
			if (!resetn_in)
			begin
				stab     <= 8'h00;
				filt[ch] <= 1'b0;
			end
			else if (sync_b[ch] == filt[ch])
				stab <= 8'h00;
			else if (stab == LIM - 8'h01)
			begin
				filt[ch] <= sync_b[ch];
				stab     <= 8'h00;
			end
			else
				stab <= stab + 8'h01;
		end

		// Short high time within the window means positive pulses
		always_ff @(posedge clock_in)
		begin
			if (!resetn_in)
			begin
				samples    <= 9'h000;
				highs      <= 9'h000;
				pol_in[ch] <= `RST_POLARITY;
			end
			else if (tick8)
			begin
				if (samples == 9'(POL_WIN - 1))
				begin
					pol_in[ch] <= highs < 9'(`POL_HALF);
					samples    <= 9'h000;
					highs      <= 9'h000;
				end
				else
				begin
					samples <= samples + 9'h001;
					highs   <= highs + {8'h00, filt[ch]};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Composite separation and pulse insertion
	// ----------------------------------------------------------------
	logic        h_act;
	logic        v_act;
	logic        h_prev;
	logic        v_prev;
	logic [11:0] run;
	logic [11:0] widen;
	logic        v_region;
	logic        v_src;
	logic        h_edge;
	logic        v_edge;
	logic [15:0] hp_cnt;
	logic [15:0] h_period;
	logic        inserting;
	logic        h_proc;

	assign h_act     = pol_in[0] ? filt[0] : ~filt[0];
	assign v_act     = pol_in[1] ? filt[1] : ~filt[1];
	assign v_region  = ~ctrl.sep_comp && (run >= 12'(`VSEP_CYC) || widen != 12'h000);
	assign v_src     = ctrl.sep_comp ? v_act : v_region;
	assign h_edge    = h_act && !h_prev;
	assign v_edge    = v_src && !v_prev;
	assign inserting = v_region && !ctrl.pulse_insert_enable_n;
	assign h_proc    = inserting ? hp_cnt < 16'(`INSERT_CYC) : h_act;

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			h_prev <= 1'b0;
			v_prev <= 1'b0;
			run    <= 12'h000;
			widen  <= 12'h000;
		end
		else
		begin
			h_prev <= h_act;
			v_prev <= v_src;
			run    <= !h_act ? 12'h000 : (&run ? run : run + 12'h001);
			if (run >= 12'(`VSEP_CYC))
				widen <= 12'(`WIDEN_CYC);
			else if (widen != 12'h000)
				widen <= widen - 12'h001;
		end
	end

	// Interval is learnt outside the vertical region only
	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			hp_cnt   <= 16'h0000;
			h_period <= 16'hffff;
		end
		else if (inserting)
			hp_cnt <= (hp_cnt >= h_period - 16'h0001) ? 16'h0000 : hp_cnt + 16'h0001;
		else if (h_edge && !v_region)
		begin
			h_period <= hp_cnt + 16'h0001;
			hp_cnt   <= 16'h0000;
		end
		else if (!(&hp_cnt))
			hp_cnt <= hp_cnt + 16'h0001;
	end

	// ----------------------------------------------------------------
	// Vertical period and horizontal pulse counters
	// ----------------------------------------------------------------
	logic [13:0] vcnt;
	logic [11:0] hcnt;
	logic [12:0] wcnt;
	logic        win_end;
	logic        h_latch;
	logic        vov_set;
	logic        hov_set;

	assign win_end = tick8 && wcnt == (ctrl.hsel ? 13'(`WIN_LONG_TICKS - 1) : 13'(`WIN_SHORT_TICKS - 1));
	assign h_latch = ctrl.fixed_window_enable_n ? v_edge : win_end;
	assign vov_set = !v_edge && tick8 && &vcnt;
	assign hov_set = !h_latch && h_edge && &hcnt;

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			vcnt                    <= 14'h0000;
			cnt.vert_period_count   <= 14'h0000;
			cnt.vert_count_overflow <= 1'b0;
		end
		else
		begin
			if (v_edge)
			begin
				cnt.vert_period_count <= vcnt;
				vcnt                  <= 14'h0000;
			end
			else if (tick8)
				vcnt <= vcnt + 14'h0001;
			cnt.vert_count_overflow <= vov_set || (cnt.vert_count_overflow && !vov_clr);
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
			wcnt <= 13'h0000;
		else if (ctrl.fixed_window_enable_n || win_end)
			wcnt <= 13'h0000;
		else if (tick8)
			wcnt <= wcnt + 13'h0001;
	end

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			hcnt                     <= 12'h000;
			cnt.horiz_pulse_count    <= 12'h000;
			cnt.horiz_count_overflow <= 1'b0;
		end
		else
		begin
			if (h_latch)
			begin
				cnt.horiz_pulse_count <= hcnt;
				hcnt                  <= {11'h000, h_edge};
			end
			else if (h_edge)
				hcnt <= hcnt + 12'h001;
			// Clearing the flag never touches hcnt
			cnt.horiz_count_overflow <= hov_set || (cnt.horiz_count_overflow && !hov_clr);
		end
	end

	// ----------------------------------------------------------------
	// Free-running generator
	// ----------------------------------------------------------------
	logic [8:0]  fr_h;
	logic [10:0] fr_l;
	logic [9:0]  fr_t;
	logic        fr_active;
	logic        fr_line_end;

	assign fr_active   = !(&ctrl.free_run_select[2:1])
	                     && (!ctrl.horiz_out_enable_n || !ctrl.vert_out_enable_n);
	assign fr_line_end = fr_h >= fr_hper(ctrl.free_run_select) - 9'h001;

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in || !fr_active)
		begin
			fr_h <= 9'h000;
			fr_l <= 11'h000;
			fr_t <= 10'h000;
		end
		else if (sys_en)
		begin
			fr_h <= fr_line_end ? 9'h000 : fr_h + 9'h001;
			if (fr_line_end && fr_l >= fr_lines(ctrl.free_run_select) - 11'h001)
			begin
				fr_l <= 11'h000;
				fr_t <= 10'h000;
			end
			else
			begin
				if (fr_line_end)
					fr_l <= fr_l + 11'h001;
				if (!(&fr_t))
					fr_t <= fr_t + 10'h001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sync and half-frequency outputs
	// ----------------------------------------------------------------
	logic h_final;
	logic v_final;
	logic hf_prev;
	logic hf_div;

	assign h_final = fr_active ? fr_h < 9'(`FR_HPULSE_TICKS) : h_proc;
	assign v_final = fr_active ? fr_t < 10'(`FR_VPULSE_TICKS) : v_src;

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			horiz_sync_out    <= 1'b0;
			vert_sync_out     <= 1'b0;
			horiz_pin_sel_out <= 1'b0;
			vert_pin_sel_out  <= 1'b0;
		end
		else
		begin
			horiz_sync_out    <= ctrl.horiz_output_polarity ? h_final : ~h_final;
			vert_sync_out     <= ctrl.vert_output_polarity ? v_final : ~v_final;
			horiz_pin_sel_out <= !ctrl.horiz_out_enable_n;
			vert_pin_sel_out  <= !ctrl.vert_out_enable_n;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			hf_prev              <= 1'b0;
			hf_div               <= 1'b0;
			half_freq_output_out <= 1'b0;
			half_pin_sel_out     <= 1'b0;
		end
		else
		begin
			hf_prev          <= half_freq_input_in;
			half_pin_sel_out <= !ctrl.half_freq_enable_n;
			if (half_freq_input_in && !hf_prev)
				hf_div <= ~hf_div;
			if (ctrl.half_freq_enable_n)
				half_freq_output_out <= 1'b0;
			else if (!ctrl.divide_bypass_n)
				half_freq_output_out <= ctrl.bypass_polarity ? half_freq_input_in : ~half_freq_input_in;
			else
				half_freq_output_out <= hf_div;
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
			rdata_out <= 8'h00;
		else if (read_in)
		begin
			case (addr_in)
				`ADDR_SYNC_CTRL:
					rdata_out <= {4'h0, ctrl.pulse_insert_enable_n, ctrl.fixed_window_enable_n,
					              ctrl.hsel, ctrl.sep_comp};
				`ADDR_SYNC_POL_CTRL:
					rdata_out <= {2'h0, filt[0], filt[1], pol_in[0], pol_in[1],
					              ctrl.horiz_output_polarity, ctrl.vert_output_polarity};
				`ADDR_HCOUNT_LO:
					rdata_out <= cnt.horiz_pulse_count[7:0];
				`ADDR_HCOUNT_HI:
					rdata_out <= {cnt.horiz_count_overflow, 3'h0, cnt.horiz_pulse_count[11:8]};
				`ADDR_VCOUNT_LO:
					rdata_out <= cnt.vert_period_count[7:0];
				`ADDR_VCOUNT_HI:
					rdata_out <= {cnt.vert_count_overflow, 1'b0, cnt.vert_period_count[13:8]};
				`ADDR_FREE_RUN_CTRL:
					rdata_out <= {5'h00, ctrl.free_run_select};
				`ADDR_HALF_FREQ_CTRL:
					rdata_out <= {ctrl.half_freq_enable_n, ctrl.divide_bypass_n, ctrl.bypass_polarity, 5'h00};
				default:
					rdata_out <= 8'h00;
			endcase
		end
	end

endmodule : hv_sync_processor

`default_nettype wire

/* verif/hv_sync_chk.sv */
// Purpose: Port-level assertions for the sync processor
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the design top below
`timescale 1ns/1ps
`default_nettype none
module hv_sync_chk (
	input wire logic       clock_in,
	input wire logic       resetn_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       write_in,
	input wire logic       read_in,
	input wire logic [7:0] rdata_out,
	input wire logic       horiz_sync_out,
	input wire logic       vert_sync_out,
	input wire logic       horiz_pin_sel_out,
	input wire logic       vert_pin_sel_out,
	input wire logic       half_freq_output_out,
	input wire logic       half_pin_sel_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!resetn_in);
	logic [7:0] wd;
	logic       wr7;
	logic       wrd;
	// ----
	// Last written byte
	// ----
	assign wr7 = write_in && addr_in == 8'h07;
	assign wrd = write_in && addr_in == 8'h0d;
	always_ff @(posedge clock_in)
	begin
		if (write_in)
			wd <= wdata_in;
	end
	rst_clear_a:
		assert property ($rose(resetn_in) |-> !{horiz_sync_out, vert_sync_out, horiz_pin_sel_out,
			vert_pin_sel_out, half_freq_output_out, half_pin_sel_out}) else $error("outputs set after reset");
	rd_hold_a:
		assert property (!read_in |=> $stable(rdata_out)) else $error("read data moved without a read");
	vcnt_width_a:
		assert property (read_in && addr_in == 8'h0b |=> rdata_out[6] == 1'b0) else $error("vcount high bad");
	hcnt_width_a:
		assert property (read_in && addr_in == 8'h09 |=> rdata_out[6:4] == 3'h0) else $error("hcount high bad");
	sel_width_a:
		assert property (read_in && addr_in == 8'h0c |=> rdata_out[7:3] == 5'h00) else $error("select read bad");
	vout_en_a:
		assert property (wr7 |=> ##[0:1] vert_pin_sel_out == !wd[6]) else $error("vertical pin select wrong");
	hout_en_a:
		assert property (wr7 |=> ##[0:1] horiz_pin_sel_out == !wd[7]) else $error("horizontal pin select wrong");
	half_en_a:
		assert property (wrd |=> ##[0:1] half_pin_sel_out == !wd[7]) else $error("half pin select wrong");
	half_idle_a:
		assert property (!half_pin_sel_out [*2] |-> !half_freq_output_out) else $error("half output while off");
	vsel_keep_a:
		assert property (!wr7 [*2] |=> $stable(vert_pin_sel_out)) else $error("pin select moved unwritten");
endmodule : hv_sync_chk
bind hv_sync_processor hv_sync_chk chk (
	.clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.write_in(write_in), .read_in(read_in), .rdata_out(rdata_out), .horiz_sync_out(horiz_sync_out),
	.vert_sync_out(vert_sync_out), .horiz_pin_sel_out(horiz_pin_sel_out), .vert_pin_sel_out(vert_pin_sel_out),
	.half_freq_output_out(half_freq_output_out), .half_pin_sel_out(half_pin_sel_out));
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the sync processor
// Assumes: Source model drives sync pins; bench drives registers and half input
// Notes:   Reads are scored by a monitor from a queue of expected bytes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [7:0]  RA [9] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h20};
	localparam logic [7:0]  RV [9] = '{8'h0f, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'he0, 8'h00};
	localparam logic [12:0] HP [4] = '{13'h0140, 13'h0190, 13'h0280, 13'h0320};
	localparam logic [15:0] FR [6] = '{16'h1900, 16'h1194, 16'h0c80, 16'h09c4, 16'h0898, 16'h0898};
	logic        clock_in, resetn_in, write_in, read_in, half_in, rdd, p;
	logic [7:0]  addr_in, wdata_in, rdata_out, e;
	logic        hs, vs, ho, vo, hsel, vsel, half_o, half_sel, en, comp, gl;
	logic [12:0] hper, vwid;
	logic [1:0]  lv;
	logic [7:0]  exp_q[$];
	int          err_count, tests_run;
	realtime     t0, t1;
	hv_sync_processor dut (
		.clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.write_in(write_in), .read_in(read_in), .rdata_out(rdata_out), .hsync_in(hs), .vsync_in(vs),
		.half_freq_input_in(half_in), .horiz_sync_out(ho), .vert_sync_out(vo), .horiz_pin_sel_out(hsel),
		.vert_pin_sel_out(vsel), .half_freq_output_out(half_o), .half_pin_sel_out(half_sel));
	vga_src src (.clk_in(clock_in), .en_in(en), .comp_in(comp), .glitch_in(gl), .hper_in(hper),
		.vwid_in(vwid), .hs_out(hs), .vs_out(vs));
	initial
	begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	// ----
	// Bus and scoring tasks
	// ----
	task automatic check(input logic [15:0] s, input logic [15:0] x);
		tests_run++;
		if (s !== x)
		begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, x);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_in  <= a;
		wdata_in <= d;
		write_in <= 1'b1;
		@(posedge clock_in);
		write_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge clock_in);
		addr_in <= a;
		read_in <= 1'b1;
		exp_q.push_back(x);
		@(posedge clock_in);
		read_in <= 1'b0;
	endtask : rd
	task automatic edge_h(output realtime t);
		int i;
		for (i = 0; ho !== 1'b0 && i < 20000; i++) @(posedge clock_in);
		for (; ho !== 1'b1 && i < 20000; i++) @(posedge clock_in);
		if (i >= 20000)
			err_count++;
		t = $realtime;
	endtask : edge_h
	task automatic meas(input logic [15:0] x);
		edge_h(t0);
		edge_h(t0);
		edge_h(t1);
		check(16'(int'((t1 - t0) / 5.0)), x);
	endtask : meas
	task automatic do_reset;
		resetn_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		resetn_in <= 1'b1;
		foreach (RA[i])
			rd(RA[i], RV[i]);
	endtask : do_reset
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	always @(posedge clock_in)
	begin
		if (rdd === 1'b1)
		begin
			e = exp_q.pop_front();
			check({8'h00, rdata_out}, {8'h00, e});
		end
		rdd <= read_in;
	end
	initial
	begin
		repeat (99000) @(posedge clock_in);
		err_count++;
		complete_run();
	end
	// ----
	// Main sequence
	// ----
	initial
	begin
		{resetn_in, write_in, read_in, half_in, en, comp, gl, rdd} = 8'h00;
		addr_in = 8'h00;
		wdata_in = 8'h00;
		vwid = 13'h0064;
		err_count = 0;
		tests_run = 0;
		void'($urandom(65));
		hper = HP[$urandom_range(3, 0)];
		do_reset();
		en <= 1'b1;
		repeat (9800) @(posedge clock_in);
		rd(8'h0a, 8'h02);
		rd(8'h0b, 8'h00);
		rd(8'h08, 8'(16'h0c80 / hper));
		rd(8'h09, 8'h00);
		// Narrow vertical pulse mid-frame must not restart the period
		repeat (1000) @(posedge clock_in);
		gl <= 1'b1;
		repeat (20) @(posedge clock_in);
		gl <= 1'b0;
		repeat (2500) @(posedge clock_in);
		rd(8'h0a, 8'h02);
		wr(8'h06, 8'h0e);
		comp <= 1'b1;
		vwid <= 13'h04b0;
		repeat (9600) @(posedge clock_in);
		rd(8'h06, 8'h0e);
		rd(8'h0a, 8'h02);
		wr(8'h06, 8'h0f);
		comp <= 1'b0;
		vwid <= 13'h0064;
		wr(8'h0c, 8'h00);
		meas({3'h0, hper});
		wr(8'h07, 8'h03);
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h0c, 8'(c));
			meas(c < 6 ? FR[c] : {3'h0, hper});
		end
		en <= 1'b0;
		wr(8'h0c, 8'h07);
		repeat (100) @(posedge clock_in);
		lv = {ho, vo};
		wr(8'h07, 8'h00);
		repeat (10) @(posedge clock_in);
		check({14'h0, ho, vo}, {14'h0, ~lv});
		wr(8'h0d, 8'h60);
		repeat (10) @(posedge clock_in);
		for (int i = 0; i < 8; i++)
		begin
			p = half_o;
			half_in <= 1'b1;
			repeat ($urandom_range(12, 8)) @(posedge clock_in);
			half_in <= 1'b0;
			repeat ($urandom_range(12, 8)) @(posedge clock_in);
			check({15'h0, half_o}, {15'h0, ~p});
		end
		wr(8'h0d, 8'h20);
		half_in <= 1'b1;
		repeat (10) @(posedge clock_in);
		check({15'h0, half_o}, 16'h0001);
		wr(8'h0d, 8'h00);
		repeat (10) @(posedge clock_in);
		check({15'h0, half_o}, 16'h0000);
		do_reset();
		repeat (4) @(posedge clock_in);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire

/* verif/vga_src.sv */
// Purpose: Video card model driving separate or composite sync
// Assumes: Periods in clock cycles; while stopped the horizontal line is low and the vertical line follows the glitch input
// Notes:   Glitch input adds a bench-timed pulse on the vertical line
`timescale 1ns/1ps
`default_nettype none
module vga_src #(
	parameter logic [12:0] VPER = 13'h0c80
) (
	input  wire logic        clk_in,
	input  wire logic        en_in,
	input  wire logic        comp_in,
	input  wire logic        glitch_in,
	input  wire logic [12:0] hper_in,
	input  wire logic [12:0] vwid_in,
	output logic             hs_out,
	output logic             vs_out
);
	logic [12:0] hc;
	logic [12:0] vc;
	always_ff @(posedge clk_in)
	begin
		hc <= (!en_in || hc == hper_in - 13'h1) ? 13'h0 : hc + 13'h1;
		vc <= (!en_in || vc == VPER - 13'h1) ? 13'h0 : vc + 13'h1;
	end
	// Composite: the vertical region holds the line high
	assign hs_out = en_in && (hc < 13'h64 || (comp_in && vc < vwid_in));
	assign vs_out = (en_in && !comp_in && vc < vwid_in) || glitch_in;
endmodule : vga_src
`default_nettype wire
